// ===== scu_cfg.svh
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SCU_OFF_CTRL 8'h00
`define SCU_OFF_STATUS 8'h04
`define SCU_OFF_INSTR0 8'h08
`define SCU_OFF_INSTR1 8'h0c
`define SCU_OFF_PC 8'h10
`define SCU_OFF_SAVED_PC 8'h14
`define SCU_OFF_FLAGS 8'h18
`define SCU_OFF_CYCLES 8'h1c
`define SCU_GPR_PAGE 2'h1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCU_CTRL_START 0
`define SCU_CTRL_SEG 1
`define SCU_ST_BUSY 0
`define SCU_ST_DONE 1
`define SCU_ST_ILLEGAL 2
`define SCU_ST_INTR 3
`define SCU_FLAG_C 7
`define SCU_FLAG_Z 6
`define SCU_FLAG_S 5
`define SCU_FLAG_V 4
`define SCU_FLAG_D 3
`define SCU_FLAG_H 2

// ----------------------------------------
// Instruction encoding
// ----------------------------------------
`define SCU_OPCODE 7'h5d
`define SCU_W1_TOP 4'h0
`define SCU_SUB_CSU 4'h0
`define SCU_SUB_CSUR 4'h4
`define SCU_SUB_SSD 4'ha
`define SCU_SUB_SSDR 4'he
`define SCU_SUB_SSU 4'h2

// ----------------------------------------
// Cycle figures
// ----------------------------------------
`define SCU_CYC_CSU 32'h0000_0014
`define SCU_CYC_SS 32'h0000_0019
`define SCU_CYC_REP_BASE 32'h0000_000b
`define SCU_CYC_CSUR_ELEM 32'h0000_0009
`define SCU_CYC_SSR_ELEM 32'h0000_000e
`define SCU_CYC_INT 32'h0000_0007

// ----------------------------------------
// Reset values and responses
// ----------------------------------------
`define SCU_RST_WORD 16'h0000
`define SCU_RST_FLAGS 8'h00
`define SCU_RESP_OKAY 2'h0
`define SCU_RESP_SLVERR 2'h2

`endif

// ===== scu_pkg.sv
`default_nettype none
package scu_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DEC = 3'h1,
      ST_RDS = 3'h3,
      ST_RDD = 3'h2,
      ST_CMP = 3'h6,
      ST_UPD = 3'h7,
      ST_FIN = 3'h5
   } scu_state_type;

   typedef enum logic [2:0] {
      OP_CSU = 3'h0,
      OP_CSUR = 3'h1,
      OP_SSD = 3'h2,
      OP_SSDR = 3'h3,
      OP_SSU = 3'h4,
      OP_BAD = 3'h7
   } scu_op_type;
endpackage : scu_pkg
`default_nettype wire

// ===== scu_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "scu_cfg.svh"

module scu_decoder (
   input wire logic [15:0] i_word0,
   input wire logic [15:0] i_word1,
   output scu_pkg::scu_op_type o_op,
   output logic o_legal,
   output logic o_word,
   output logic [3:0] o_src_f,
   output logic [3:0] o_cnt_f,
   output logic [3:0] o_dst_f,
   output logic [3:0] o_cc
);
   import scu_pkg::*;

   assign o_src_f = i_word0[7:4];
   assign o_cnt_f = i_word1[11:8];
   assign o_dst_f = i_word1[7:4];
   assign o_cc = i_word1[3:0];
   assign o_word = i_word0[8];

   always_comb begin
      unique case (i_word0[3:0])
         `SCU_SUB_CSU: o_op = OP_CSU;
         `SCU_SUB_CSUR: o_op = OP_CSUR;
         `SCU_SUB_SSD: o_op = OP_SSD;
         `SCU_SUB_SSDR: o_op = OP_SSDR;
         `SCU_SUB_SSU: o_op = OP_SSU;
         default: o_op = OP_BAD;
      endcase
   end

   assign o_legal = (i_word0[15:9] == `SCU_OPCODE) && (i_word1[15:12] == `SCU_W1_TOP) &&
                    (o_op != OP_BAD) && (o_src_f != 4'h0) && (o_dst_f != 4'h0);
endmodule : scu_decoder
`default_nettype wire

// ===== scu_compare.sv
`timescale 1ns/10ps
`default_nettype none

module scu_compare (
   input wire logic i_word,
   input wire logic [15:0] i_dst,
   input wire logic [15:0] i_src,
   input wire logic [3:0] i_cc,
   output logic o_match,
   output logic o_carry,
   output logic o_sign
);
   logic [16:0] diff;
   logic zero;
   logic ovf;
   logic dmsb;
   logic smsb;

   // Low three bits of the code pick a test, top bit inverts it
   function automatic logic cc_eval(input logic [3:0] cc, input logic c, input logic z,
                                    input logic s, input logic v);
      logic t;
      t = 1'b0;
      unique case (cc[2:0])
         3'h0: t = 1'b0;
         3'h1: t = s ^ v;
         3'h2: t = z | (s ^ v);
         3'h3: t = c | z;
         3'h4: t = v;
         3'h5: t = s;
         3'h6: t = z;
         3'h7: t = c;
      endcase
      cc_eval = cc[3] ^ t;
   endfunction : cc_eval

   assign diff = {1'b0, i_dst} - {1'b0, i_src};
   assign dmsb = i_word ? i_dst[15] : i_dst[7];
   assign smsb = i_word ? i_src[15] : i_src[7];
   assign o_carry = i_word ? diff[16] : (i_dst[7:0] < i_src[7:0]);
   assign o_sign = i_word ? diff[15] : diff[7];
   assign zero = i_word ? (diff[15:0] == 16'h0000) : (diff[7:0] == 8'h00);
   assign ovf = (dmsb != smsb) && (o_sign == smsb);
   assign o_match = cc_eval(i_cc, o_carry, zero, o_sign, ovf);
endmodule : scu_compare
`default_nettype wire

// ===== scu_top.sv
// Notes on behaviour
// - Register forms compare register minus memory; Z shows condition, operands kept.
// - Register step-up forms advance source by 1 or 2, then count down.
// - V is set when the decremented counter is zero, else cleared.
// - Repeat forms loop until condition holds or counter reaches zero.
// - Repeat forms stop for interrupts between steps, saving instruction start address.
// - Every accepted interrupt adds seven cycles to the instruction's total.
// - Pointers are one word register unsegmented, register pair segmented.
// - String forms compare destination element minus source element; Z shows condition.
// - String step-down forms lower both pointers by 1 or 2, count down.
// - String step-down repeat gives carry as borrow and sign of last compare.
// - Decode fixed opcode, fields, sub-operation; pointer fields must be non-zero.
// - Register step-up repeat uses 0100, 11+9n cycles; single form 20.
// - String step-down single uses 1010 and takes 25 cycles.
// - String step-up single uses 0010, 25 cycles; step-down repeat 1110, 11+14n.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "scu_cfg.svh"

module scu_top (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic o_mem_req,
   output logic o_mem_word,
   output logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [15:0] i_mem_rdata,
   input wire logic i_int_req,
   output logic o_int_ack,
   output logic o_busy
);
   import scu_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   scu_state_type state_r;
   scu_op_type op;
   logic [15:0] gpr_r [0:15];
   logic [15:0] instr0_r;
   logic [15:0] instr1_r;
   logic [15:0] pc_r;
   logic [15:0] saved_pc_r;
   logic [7:0] flags_r;
   logic [31:0] cycles_r;
   logic seg_r;
   logic st_done_r;
   logic st_illegal_r;
   logic st_intr_r;
   logic add_base_r;
   logic [31:0] mem_addr_r;
   logic [15:0] src_data_r;
   logic [15:0] dst_data_r;
   logic match_r;
   logic carry_r;
   logic sign_r;
   logic int_ack_r;
   logic [7:0] aw_addr_r;
   logic aw_held_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_held_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;

   logic legal;
   logic word;
   logic [3:0] src_f;
   logic [3:0] cnt_f;
   logic [3:0] dst_f;
   logic [3:0] cc;
   logic is_string;
   logic is_repeat;
   logic is_down;
   logic [15:0] step;
   logic [15:0] cnt_nxt;
   logic [3:0] src_oi;
   logic [3:0] dst_oi;
   logic [15:0] cmp_dst;
   logic cmp_match;
   logic cmp_carry;
   logic cmp_sign;
   logic go_on;
   logic take_int;
   logic do_wr;
   logic idle;
   logic start;
   logic [31:0] rd_mux;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && ((a[7:6] == `SCU_GPR_PAGE) || (a <= `SCU_OFF_CYCLES));
   endfunction : mapped

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   function automatic logic [3:0] off_idx(input logic [3:0] f, input logic seg);
      off_idx = seg ? (f | 4'h1) : f;
   endfunction : off_idx

   function automatic logic [31:0] ptr_addr(input logic [3:0] f, input logic seg);
      ptr_addr = seg ? {gpr_r[f & 4'he], gpr_r[f | 4'h1]} : {16'h0000, gpr_r[f]};
   endfunction : ptr_addr

   // ----------------------------------------
   // Decode and compare
   // ----------------------------------------
   scu_decoder u_dec (
      .i_word0(instr0_r),
      .i_word1(instr1_r),
      .o_op(op),
      .o_legal(legal),
      .o_word(word),
      .o_src_f(src_f),
      .o_cnt_f(cnt_f),
      .o_dst_f(dst_f),
      .o_cc(cc)
   );

   assign is_string = (op == OP_SSD) || (op == OP_SSDR) || (op == OP_SSU);
   assign is_repeat = (op == OP_CSUR) || (op == OP_SSDR);
   assign is_down = (op == OP_SSD) || (op == OP_SSDR);
   assign step = word ? 16'h0002 : 16'h0001;
   assign src_oi = off_idx(src_f, seg_r);
   assign dst_oi = off_idx(dst_f, seg_r);
   // Counter wraps from 0 to FFFF, so a zero count means 65536 elements
   assign cnt_nxt = gpr_r[cnt_f] - 16'h0001;

   // register operand, byte lanes split high/low
   always_comb begin
      if (is_string) begin
         cmp_dst = dst_data_r;
      end else if (word) begin
         cmp_dst = gpr_r[dst_f];
      end else begin
         cmp_dst = dst_f[3] ? {8'h00, gpr_r[{1'b0, dst_f[2:0]}][7:0]} :
                              {8'h00, gpr_r[{1'b0, dst_f[2:0]}][15:8]};
      end
   end

   scu_compare u_cmp (
      .i_word(word),
      .i_dst(cmp_dst),
      .i_src(src_data_r),
      .i_cc(cc),
      .o_match(cmp_match),
      .o_carry(cmp_carry),
      .o_sign(cmp_sign)
   );

   // loop while no match and count left
   assign go_on = is_repeat && !match_r && (cnt_nxt != 16'h0000);
   assign take_int = go_on && i_int_req;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   assign idle = (state_r == ST_IDLE);
   assign start = do_wr && idle && (aw_addr_r == `SCU_OFF_CTRL) && w_strb_r[0] && w_data_r[`SCU_CTRL_START];

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= ST_IDLE;
         mem_addr_r <= 32'h0000_0000;
         src_data_r <= `SCU_RST_WORD;
         dst_data_r <= `SCU_RST_WORD;
         match_r <= 1'b0;
         carry_r <= 1'b0;
         sign_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r <= ST_DEC;
               end
            end
            ST_DEC: begin
               // Reached again on each repeat step, so the source pointer is re-read here
               mem_addr_r <= ptr_addr(src_f, seg_r);
               state_r <= legal ? ST_RDS : ST_FIN;
            end
            ST_RDS: begin
               if (i_mem_ack) begin
                  src_data_r <= word ? i_mem_rdata : {8'h00, i_mem_rdata[7:0]};
                  mem_addr_r <= ptr_addr(dst_f, seg_r);
                  state_r <= is_string ? ST_RDD : ST_CMP;
               end
            end
            ST_RDD: begin
               if (i_mem_ack) begin
                  dst_data_r <= word ? i_mem_rdata : {8'h00, i_mem_rdata[7:0]};
                  state_r <= ST_CMP;
               end
            end
            ST_CMP: begin
               match_r <= cmp_match;
               carry_r <= cmp_carry;
               sign_r <= cmp_sign;
               state_r <= ST_UPD;
            end
            ST_UPD: begin
               state_r <= (go_on && !take_int) ? ST_DEC : ST_FIN;
            end
            ST_FIN: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign o_mem_req = (state_r == ST_RDS) || (state_r == ST_RDD);
   assign o_mem_word = word;
   assign o_mem_addr = mem_addr_r;
   assign o_busy = !idle;
   assign o_int_ack = int_ack_r;

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < 16; i++) begin
            gpr_r[i] <= `SCU_RST_WORD;
         end
      end else if (state_r == ST_UPD) begin
         if (is_down) begin
            gpr_r[src_oi] <= gpr_r[src_oi] - step;
            gpr_r[dst_oi] <= gpr_r[dst_oi] - step;
         end else if (is_string) begin
            gpr_r[src_oi] <= gpr_r[src_oi] + step;
            gpr_r[dst_oi] <= gpr_r[dst_oi] + step;
         end else begin
            gpr_r[src_oi] <= gpr_r[src_oi] + step;
         end
         // sixteen-bit counter, count kept valid by software
         gpr_r[cnt_f] <= cnt_nxt;
      end else if (do_wr && idle && (aw_addr_r[7:6] == `SCU_GPR_PAGE)) begin
         gpr_r[aw_addr_r[5:2]] <= merge16(gpr_r[aw_addr_r[5:2]], w_data_r, w_strb_r);
      end
   end

   // ----------------------------------------
   // Flags
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         flags_r <= `SCU_RST_FLAGS;
      end else if (state_r == ST_UPD) begin
         flags_r[`SCU_FLAG_Z] <= match_r;
         flags_r[`SCU_FLAG_V] <= (cnt_nxt == 16'h0000);
         flags_r[`SCU_FLAG_C] <= carry_r;
         flags_r[`SCU_FLAG_S] <= sign_r;
      end else if (do_wr && idle && (aw_addr_r == `SCU_OFF_FLAGS) && w_strb_r[0]) begin
         flags_r <= w_data_r[7:0];
      end
   end

   // ----------------------------------------
   // Status, cycle count, saved address
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_done_r <= 1'b0;
         st_illegal_r <= 1'b0;
         st_intr_r <= 1'b0;
         add_base_r <= 1'b0;
         cycles_r <= 32'h0000_0000;
         saved_pc_r <= `SCU_RST_WORD;
         int_ack_r <= 1'b0;
      end else begin
         int_ack_r <= 1'b0;
         if (start) begin
            st_done_r <= 1'b0;
            st_illegal_r <= 1'b0;
            st_intr_r <= 1'b0;
            // A resumed instruction keeps its running total
            add_base_r <= !st_intr_r;
            if (!st_intr_r) begin
               cycles_r <= 32'h0000_0000;
            end
         end
         if (state_r == ST_DEC) begin
            add_base_r <= 1'b0;
            if (!legal) begin
               st_illegal_r <= 1'b1;
            end else if (add_base_r) begin
               unique case (op)
                  OP_CSU: cycles_r <= `SCU_CYC_CSU;
                  OP_SSD, OP_SSU: cycles_r <= `SCU_CYC_SS;
                  default: cycles_r <= `SCU_CYC_REP_BASE;
               endcase
            end
         end
         if (state_r == ST_UPD) begin
            if (take_int) begin
               cycles_r <= cycles_r + (is_string ? `SCU_CYC_SSR_ELEM : `SCU_CYC_CSUR_ELEM) + `SCU_CYC_INT;
               saved_pc_r <= pc_r;
               st_intr_r <= 1'b1;
               int_ack_r <= 1'b1;
            end else if (is_repeat) begin
               cycles_r <= cycles_r + (is_string ? `SCU_CYC_SSR_ELEM : `SCU_CYC_CSUR_ELEM);
            end
         end
         if (state_r == ST_FIN) begin
            st_done_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Control words
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         seg_r <= 1'b0;
         instr0_r <= `SCU_RST_WORD;
         instr1_r <= `SCU_RST_WORD;
         pc_r <= `SCU_RST_WORD;
      end else if (do_wr && idle) begin
         if ((aw_addr_r == `SCU_OFF_CTRL) && w_strb_r[0]) begin
            seg_r <= w_data_r[`SCU_CTRL_SEG];
         end
         if (aw_addr_r == `SCU_OFF_INSTR0) begin
            instr0_r <= merge16(instr0_r, w_data_r, w_strb_r);
         end
         if (aw_addr_r == `SCU_OFF_INSTR1) begin
            instr1_r <= merge16(instr1_r, w_data_r, w_strb_r);
         end
         if (aw_addr_r == `SCU_OFF_PC) begin
            pc_r <= merge16(pc_r, w_data_r, w_strb_r);
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   assign do_wr = aw_held_r && w_held_r && !bvalid_r;
   assign o_s_axi_awready = !aw_held_r && !bvalid_r;
   assign o_s_axi_wready = !w_held_r && !bvalid_r;
   assign o_s_axi_bvalid = bvalid_r;
   assign o_s_axi_bresp = bresp_r;
   assign o_s_axi_arready = !rvalid_r;
   assign o_s_axi_rvalid = rvalid_r;
   assign o_s_axi_rresp = rresp_r;
   assign o_s_axi_rdata = rdata_r;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `SCU_RESP_OKAY;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= i_s_axi_wdata;
            w_strb_r <= i_s_axi_wstrb;
         end
         if (do_wr) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= mapped(aw_addr_r) ? `SCU_RESP_OKAY : `SCU_RESP_SLVERR;
         end else if (bvalid_r && i_s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (i_s_axi_araddr[7:6] == `SCU_GPR_PAGE) begin
         rd_mux = {16'h0000, gpr_r[i_s_axi_araddr[5:2]]};
      end else begin
         unique case (i_s_axi_araddr)
            `SCU_OFF_CTRL: rd_mux = {30'h0000_0000, seg_r, 1'b0};
            `SCU_OFF_STATUS: rd_mux = {28'h000_0000, st_intr_r, st_illegal_r, st_done_r, !idle};
            `SCU_OFF_INSTR0: rd_mux = {16'h0000, instr0_r};
            `SCU_OFF_INSTR1: rd_mux = {16'h0000, instr1_r};
            `SCU_OFF_PC: rd_mux = {16'h0000, pc_r};
            `SCU_OFF_SAVED_PC: rd_mux = {16'h0000, saved_pc_r};
            `SCU_OFF_FLAGS: rd_mux = {24'h00_0000, flags_r};
            `SCU_OFF_CYCLES: rd_mux = cycles_r;
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rvalid_r <= 1'b0;
         rresp_r <= `SCU_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else if (i_s_axi_arvalid && o_s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r <= mapped(i_s_axi_araddr) ? `SCU_RESP_OKAY : `SCU_RESP_SLVERR;
         rdata_r <= rd_mux;
      end else if (rvalid_r && i_s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule : scu_top
`default_nettype wire

// ===== scu_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module scu_chk (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic o_mem_req,
   input wire logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic o_int_ack,
   input wire logic o_busy
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   sequence both_taken;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
   endsequence
   chk_req_busy: assert property (o_mem_req |-> o_busy)
      else $error("memory read while idle");
   chk_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
      else $error("read request dropped or moved");
   chk_intack_pulse: assert property (o_int_ack |=> !o_int_ack)
      else $error("interrupt ack too long");
   chk_intack_stop: assert property ($rose(o_int_ack) |-> ##[0:3] !o_busy)
      else $error("no stop after interrupt");
   chk_write_resp: assert property (both_taken |=> ##1 o_s_axi_bvalid)
      else $error("write response late");
   chk_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
      else $error("write response dropped");
   chk_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
      else $error("read data dropped");
   chk_ar_block: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
      else $error("second read taken");
endmodule : scu_chk
bind scu_top scu_chk chk_u (.*);
`default_nettype wire

// ===== scu_mem.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// String memory, random wait states
// ------------------------------
module scu_mem (
   input wire logic i_core_clk,
   input wire logic i_req,
   input wire logic i_word,
   input wire logic [31:0] i_addr,
   output logic o_ack,
   output logic [15:0] o_rdata
);
   logic [1:0] wait_r = 2'h0;
   initial o_ack = 1'b0;
   initial o_rdata = 16'h0000;
   function automatic logic [7:0] bt(input logic [31:0] a);
      return a[7:0] ^ 8'h3c;
   endfunction : bt
   always @(posedge i_core_clk) begin
      o_ack <= 1'b0;
      // Bus not driven: toggles so stale data never looks valid
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
         if (wait_r == 2'h0) begin
            o_ack <= 1'b1;
            o_rdata <= i_word ? {bt(i_addr), bt(i_addr + 1)} : {~bt(i_addr), bt(i_addr)};
            wait_r <= 2'($urandom % 3);
         end else begin
            wait_r <= wait_r - 2'h1;
         end
      end
   end
endmodule : scu_mem
`default_nettype wire

// ===== scu_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Bench
// ------------------------------
module scu_bench;
   logic clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, irq = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd;
   logic [1:0] rs, ws;
   logic [15:0] s, d, c;
   wire awr, wr_, bv, arr, rv, req, wrd, ack, iack, busy;
   wire [1:0] br, rr;
   wire [31:0] rdat, maddr;
   wire [15:0] mdat;
   int n_fail = 0, n_checks = 0;
   scu_top dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
      .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
      .o_s_axi_wready(wr_), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
      .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdat),
      .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_mem_req(req), .o_mem_word(wrd),
      .o_mem_addr(maddr), .i_mem_ack(ack), .i_mem_rdata(mdat), .i_int_req(irq), .o_int_ack(iack), .o_busy(busy));
   scu_mem mem_u (.i_core_clk(clk), .i_req(req), .i_word(wrd), .i_addr(maddr), .o_ack(ack), .o_rdata(mdat));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic pa, pw, ta, tw;
      pa = 1;
      pw = 1;
      @(posedge clk);
      awa <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1;
      do begin
         @(negedge clk);
         ta = pa && awr;
         tw = pw && wr_;
         @(posedge clk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
         pa = pa && !ta;
         pw = pw && !tw;
      end while (pa || pw);
      // Response taken at the edge that samples bvalid high
      do @(posedge clk); while (bv !== 1'b1);
      ws = br;
      bry <= 0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      ara <= a; arv <= 1; rry <= 1;
      do @(negedge clk); while (arr !== 1'b1);
      @(posedge clk);
      arv <= 0;
      do @(posedge clk); while (rv !== 1'b1);
      rd = rdat;
      rs = rr;
      rry <= 0;
   endtask : rdr
   task automatic fin();
      rd = 0;
      for (int i = 0; i < 300 && rd[1] !== 1'b1; i++) rdr(8'h04);
      chk("done", rd[1], 1);
   endtask : fin
   // Register forms use low byte of R2 for bytes; string forms use R2 as pointer
   task automatic go(input logic [3:0] sub, input logic w, input logic [3:0] cc, input logic [15:0] s0, d0, c0);
      logic z;
      int n, k, ki;
      logic [15:0] e, x, st;
      logic [16:0] df;
      s = s0; d = d0; c = c0; n = 0; st = w ? 16'h0002 : 16'h0001;
      wr(8'h44, s0); wr(8'h48, d0); wr(8'h4c, c0);
      wr(8'h10, s0 ^ 16'h0f0f);
      wr(8'h08, {7'h5d, w, 4'h1, sub});
      wr(8'h0c, {8'h03, (w || sub[1]) ? 4'h2 : 4'ha, cc});
      wr(8'h00, 1);
      do begin
         e = w ? {mem_u.bt(s), mem_u.bt(s + 1)} : mem_u.bt(s);
         x = sub[1] ? (w ? {mem_u.bt(d), mem_u.bt(d + 1)} : mem_u.bt(d)) : (w ? d0 : d0[7:0]);
         z = (x == e) ^ cc[3];
         df = {1'b0, x} - e;
         n++;
         s = sub[3] ? s - st : s + st;
         if (sub[1]) d = sub[3] ? d - st : d + st;
         c = c - 1;
      end while (sub[2] && !z && c != 0);
      fin();
      // With the request held, every repeat step but the last is interrupted
      ki = (irq && sub[2]) ? n - 1 : 0;
      for (k = 0; rd[3] === 1'b1 && k < 9; k++) begin
         wr(8'h00, 1);
         fin();
      end
      chk("interrupts", k, ki);
      if (irq) begin
         rdr(8'h14);
         chk("saved_pc", rd, s0 ^ 16'h0f0f);
      end
      rdr(8'h44); chk("src_ptr", rd, s);
      rdr(8'h48); chk("dst", rd, d);
      rdr(8'h4c); chk("count", rd, c);
      rdr(8'h18); chk("z_v", {rd[6], rd[4]}, {z, c == 0});
      if (sub == 4'he) chk("c_s", {rd[7], rd[5]}, {df[16], w ? df[15] : df[7]});
      rdr(8'h1c); chk("cycles", rd, (sub[2] ? 11 + (sub[1] ? 14 : 9) * n : (sub[1] ? 25 : 20)) + 7 * ki);
      $display("test %h done", sub);
   endtask : go
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'hb878_fe8c));
      repeat (8) @(posedge clk);
      rstn <= 1;
      rdr(8'h18); chk("flags_reset", rd, 0);
      rdr(8'h30); chk("unmapped", rs, 2);
      wr(8'h30, 0); chk("unmapped_w", ws, 2);
      go(4'h0, 0, 4'h6, 16'($urandom), 16'($urandom), 16'h0001);
      go(4'h4, 1, 4'h6, 16'h1000, 16'h3839, 16'h0005);
      irq <= 1;
      go(4'h4, 1, 4'h6, 16'h1000, 16'h3839, 16'h0005);
      irq <= 0;
      go(4'ha, 0, 4'h6, 16'h1000, 16'h2000, 16'h0002);
      go(4'h2, 1, 4'h6, 16'h1000, 16'h2000, 16'h0001);
      go(4'he, 1, 4'he, 16'h1010, 16'h2010, 16'h0004);
      go(4'he, 0, 4'he, 16'h1010, 16'h2030, 16'h0003);
      wr(8'h08, 32'h0000_ba00);
      wr(8'h00, 1);
      fin();
      chk("illegal", rd[2], 1);
      $display("test illegal done");
      tally_and_finish();
   end
endmodule : scu_bench
`default_nettype wire
